//--- rtl/literal_move_multiply_exec.sv
// execution of literal loads, store of working reg and literal multiply
// assumes decode stage holds instr_i stable while instr_valid_i is high in the decode phase;
// the register file takes file_we_o with file_addr_o and file_data_o; fsr2 supplied by the core
// Function
// - load literal into working register, flags untouched
// - store working register to file, flags untouched
// - access bit clear: address in access bank
// - access bit set: bank select chooses bank
// - extended set, access bit clear, low address: indexed offset mode
// - multiply literal: unsigned working times literal
// - product is full sixteen bits
// - high byte high, low byte low, working kept
// - multiply changes no status flag
// - bank load: six bits, top two zero
module literal_move_multiply_exec
  import lmm_exec_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic instr_valid_i,
  input wire logic [15:0] instr_i,
  input wire logic ext_set_en_i,
  input wire logic [13:0] index_base_i,
  output logic [7:0] working_o,
  output logic [7:0] bank_select_reg_o,
  output logic [7:0] product_high_o,
  output logic [7:0] product_low_o,
  output logic file_we_o,
  output logic [13:0] file_addr_o,
  output logic [7:0] file_data_o,
  output logic [1:0] phase_o,
  output logic [1:0] addr_mode_o,
  output logic busy_o
);

  typedef enum logic [2:0] {
    K_NONE,
    K_LOAD_WORKING,
    K_LOAD_BANK,
    K_STORE,
    K_MULTIPLY
  } kind_t;

  function automatic kind_t decode_kind(input logic [15:0] w);
    kind_t k;
    k = K_NONE;
    if (w[15:8] == OP_LOAD_WORKING) k = K_LOAD_WORKING;
    else if (w[15:8] == OP_MULTIPLY) k = K_MULTIPLY;
    else if (w[15:8] == OP_LOAD_BANK && w[7:6] == OP_LOAD_BANK_TOP) k = K_LOAD_BANK;
    else if (w[15:9] == OP_STORE_TOP) k = K_STORE;
    return k;
  endfunction

  phase_t phase_q, phase_d;
  kind_t kind_q, kind_d;
  logic [7:0] lit_q, lit_d;
  logic acc_q, acc_d;
  logic [7:0] opnd_q, opnd_d;
  logic [15:0] prod_q, prod_d;
  addr_mode_t mode_q, mode_d;
  logic [13:0] addr_q, addr_d;
  logic [7:0] working_q, working_d;
  logic [7:0] bank_q, bank_d;
  logic [7:0] prod_hi_q, prod_hi_d;
  logic [7:0] prod_lo_q, prod_lo_d;
  logic we_q, we_d;
  logic [7:0] wdata_q, wdata_d;
  logic busy_q, busy_d;

  always_comb begin
    phase_d = phase_q;
    kind_d = kind_q;
    lit_d = lit_q;
    acc_d = acc_q;
    opnd_d = opnd_q;
    prod_d = prod_q;
    mode_d = mode_q;
    addr_d = addr_q;
    working_d = working_q;
    bank_d = bank_q;
    prod_hi_d = prod_hi_q;
    prod_lo_d = prod_lo_q;
    we_d = 1'b0;
    wdata_d = wdata_q;
    busy_d = busy_q;
    case (phase_q)
      PH_DECODE: begin
        if (instr_valid_i) begin
          kind_d = decode_kind(instr_i);
          lit_d = instr_i[7:0];
          acc_d = instr_i[8];
          busy_d = 1'b1;
        end else begin
          kind_d = K_NONE;
          busy_d = 1'b0;
        end
        phase_d = PH_READ;
      end
      PH_READ: begin
        // store reads the working reg, the rest read their literal
        opnd_d = (kind_q == K_STORE) ? working_q : lit_q;
        phase_d = PH_PROCESS;
      end
      PH_PROCESS: begin
        // widen both factors first so no lint tool sees an 8-bit product
        prod_d = 16'(working_q) * 16'(opnd_q);
        if (acc_q) begin
          mode_d = MODE_BANKED;
          addr_d = {bank_q[5:0], lit_q};
        end else if (ext_set_en_i && lit_q <= INDEXED_LIMIT) begin
          mode_d = MODE_INDEXED;
          addr_d = index_base_i + {6'h00, lit_q};
        end else begin
          mode_d = MODE_ACCESS;
          // low part of the access bank maps to bank 0, the rest to the sfr area
          addr_d = (lit_q < ACCESS_SPLIT) ? {2'h0, ACCESS_LOW_BANK, lit_q}
                                          : {2'h0, ACCESS_HIGH_BANK, lit_q};
        end
        phase_d = PH_WRITE;
      end
      PH_WRITE: begin
        case (kind_q)
          K_LOAD_WORKING: working_d = lit_q;
          K_LOAD_BANK: bank_d = {2'h0, lit_q[BANK_LITERAL_BITS-1:0]};
          K_STORE: begin
            we_d = 1'b1;
            wdata_d = opnd_q;
          end
          K_MULTIPLY: begin
            // working reg left alone, no flag output exists at all
            prod_hi_d = prod_q[15:8];
            prod_lo_d = prod_q[7:0];
          end
          default: ;
        endcase
        phase_d = PH_DECODE;
      end
      default: phase_d = PH_DECODE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      phase_q <= PH_DECODE;
      kind_q <= K_NONE;
      lit_q <= RESET_BYTE;
      acc_q <= 1'b0;
      opnd_q <= RESET_BYTE;
      prod_q <= 16'h0000;
      mode_q <= MODE_ACCESS;
      addr_q <= 14'h0000;
      working_q <= RESET_BYTE;
      bank_q <= RESET_BYTE;
      prod_hi_q <= RESET_BYTE;
      prod_lo_q <= RESET_BYTE;
      we_q <= 1'b0;
      wdata_q <= RESET_BYTE;
      busy_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      kind_q <= kind_d;
      lit_q <= lit_d;
      acc_q <= acc_d;
      opnd_q <= opnd_d;
      prod_q <= prod_d;
      mode_q <= mode_d;
      addr_q <= addr_d;
      working_q <= working_d;
      bank_q <= bank_d;
      prod_hi_q <= prod_hi_d;
      prod_lo_q <= prod_lo_d;
      we_q <= we_d;
      wdata_q <= wdata_d;
      busy_q <= busy_d;
    end
  end

  assign working_o = working_q;
  assign bank_select_reg_o = bank_q;
  assign product_high_o = prod_hi_q;
  assign product_low_o = prod_lo_q;
  assign file_we_o = we_q;
  assign file_addr_o = addr_q;
  assign file_data_o = wdata_q;
  assign phase_o = phase_q;
  assign addr_mode_o = mode_q;
  assign busy_o = busy_q;

  sequence s_cycle;
    phase_q == PH_DECODE ##1 phase_q == PH_READ ##1 phase_q == PH_PROCESS
      ##1 phase_q == PH_WRITE;
  endsequence

  a_phase_order: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    phase_q == PH_DECODE |-> s_cycle ##1 phase_q == PH_DECODE)
    else $error("phase order broken");

  a_load_working: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    phase_q == PH_DECODE && instr_valid_i && instr_i[15:8] == OP_LOAD_WORKING
      |-> ##4 working_q == $past(instr_i[7:0], 4))
    else $error("working load wrong");

  a_bank_top_zero: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    bank_q[7:6] == 2'h0)
    else $error("bank upper bits set");

  a_store_data: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    phase_q == PH_DECODE && instr_valid_i && instr_i[15:9] == OP_STORE_TOP
      |-> ##4 file_we_o && file_data_o == $past(working_q, 3))
    else $error("store data wrong");

  a_banked_addr: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    phase_q == PH_PROCESS && acc_q |=> addr_q == {bank_q[5:0], lit_q})
    else $error("banked address wrong");

  a_indexed_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    phase_q == PH_PROCESS && !acc_q && ext_set_en_i && lit_q <= INDEXED_LIMIT
      |=> mode_q == MODE_INDEXED)
    else $error("indexed mode missed");

  a_access_mode: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    phase_q == PH_PROCESS && !acc_q && !(ext_set_en_i && lit_q <= INDEXED_LIMIT)
      |=> mode_q == MODE_ACCESS && addr_q[13:12] == 2'h0)
    else $error("access bank address wrong");

  a_product_value: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    phase_q == PH_DECODE && instr_valid_i && instr_i[15:8] == OP_MULTIPLY
      |-> ##4 {prod_hi_q, prod_lo_q} == 16'($past(working_q, 4)) * 16'($past(instr_i[7:0], 4)))
    else $error("product wrong");

  a_mult_keeps_w: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    phase_q == PH_DECODE && instr_valid_i && instr_i[15:8] == OP_MULTIPLY
      |-> ##4 working_q == $past(working_q, 4))
    else $error("multiply changed working reg");

  a_write_phase: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
    file_we_o |-> phase_q == PH_DECODE && $past(phase_q) == PH_WRITE)
    else $error("file write outside last phase");

endmodule // literal_move_multiply_exec

//--- rtl/lmm_exec_pkg.sv
// constants for the literal/move/multiply execution block
// assumes one 16-bit instruction word handed over per four-phase cycle
package lmm_exec_pkg;
  localparam logic [7:0] OP_LOAD_WORKING = 8'h0e;
  localparam logic [7:0] OP_MULTIPLY = 8'h0d;
  localparam logic [7:0] OP_LOAD_BANK = 8'h01;
  localparam logic [1:0] OP_LOAD_BANK_TOP = 2'h0;
  localparam logic [6:0] OP_STORE_TOP = 7'h37;
  localparam logic [7:0] INDEXED_LIMIT = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'h4;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam int BANK_LITERAL_BITS = 6;
  typedef enum logic [1:0] {
    MODE_ACCESS,
    MODE_BANKED,
    MODE_INDEXED
  } addr_mode_t;
  typedef enum logic [1:0] {
    PH_DECODE,
    PH_READ,
    PH_PROCESS,
    PH_WRITE
  } phase_t;
endpackage

//--- bench/tb.sv
// self-checking bench for the literal/move/multiply execution block
// assumes the block alone, driven directly, one instruction per four clocks
module tb
  import lmm_exec_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clk_sys_i;
  logic rst_n_i;
  logic instr_valid_i;
  logic [15:0] instr_i;
  logic ext_set_en_i;
  logic [13:0] index_base_i;
  logic [7:0] working_o;
  logic [7:0] bank_select_reg_o;
  logic [7:0] product_high_o;
  logic [7:0] product_low_o;
  logic file_we_o;
  logic [13:0] file_addr_o;
  logic [7:0] file_data_o;
  logic [1:0] phase_o;
  logic [1:0] addr_mode_o;
  logic busy_o;
  int error_cnt = 0;
  int num_checks = 0;

  literal_move_multiply_exec u_literal_move_multiply_exec (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .instr_valid_i(instr_valid_i),
    .instr_i(instr_i),
    .ext_set_en_i(ext_set_en_i),
    .index_base_i(index_base_i),
    .working_o(working_o),
    .bank_select_reg_o(bank_select_reg_o),
    .product_high_o(product_high_o),
    .product_low_o(product_low_o),
    .file_we_o(file_we_o),
    .file_addr_o(file_addr_o),
    .file_data_o(file_data_o),
    .phase_o(phase_o),
    .addr_mode_o(addr_mode_o),
    .busy_o(busy_o)
  );

  initial begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end

  task automatic test_done;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic step;
    @(posedge clk_sys_i);
    #1;
  endtask

  // one full instruction cycle; returns just after the write-phase edge
  task automatic exec(input logic [15:0] ins);
    instr_i = ins;
    instr_valid_i = 1'b1;
    step();
    instr_valid_i = 1'b0;
    for (int k = 1; k < 4; k++) begin
      chk("phase", 16'(phase_o), 16'(k));
      chk("busy", 16'(busy_o), 16'h0001);
      chk("write pulse", 16'(file_we_o), 16'h0000);
      if (k < 3) step();
    end
    step();
  endtask

  task automatic t_bank;
    exec({OP_LOAD_BANK, 8'h3f});
    chk("bank", 16'(bank_select_reg_o), 16'h003f);
    // top bits set: not a bank load, so the whole word must be ignored
    exec({OP_LOAD_BANK, 8'hc5});
    chk("bank", 16'(bank_select_reg_o), 16'h003f);
    exec({OP_LOAD_BANK, 8'h05});
    chk("bank", 16'(bank_select_reg_o), 16'h0005);
    $display("test bank done");
  endtask

  task automatic t_mul(input logic [7:0] w, input logic [7:0] k);
    exec({OP_LOAD_WORKING, w});
    chk("working", 16'(working_o), 16'(w));
    exec({OP_MULTIPLY, k});
    chk("product", {product_high_o, product_low_o}, 16'(w) * 16'(k));
    chk("product high", 16'(product_high_o), (16'(w) * 16'(k)) >> 8);
    chk("working", 16'(working_o), 16'(w));
    $display("test multiply %h x %h done", w, k);
  endtask

  task automatic t_store(input logic a, input logic [7:0] f, input logic ext,
                         input logic [13:0] addr, input addr_mode_t mode);
    ext_set_en_i = ext;
    exec({OP_STORE_TOP, a, f});
    chk("write pulse", 16'(file_we_o), 16'h0001);
    chk("data", 16'(file_data_o), 16'h004f);
    chk("address", 16'(file_addr_o), 16'(addr));
    chk("mode", 16'(addr_mode_o), 16'(mode));
    $display("test store a=%b f=%h done", a, f);
  endtask

  // no valid word at a decode edge: the cycle runs empty and busy drops
  task automatic t_idle;
    step();
    chk("busy idle", 16'(busy_o), 16'h0000);
    chk("phase idle", 16'(phase_o), 16'h0001);
    repeat (3) step();
    chk("phase idle", 16'(phase_o), 16'h0000);
    chk("write idle", 16'(file_we_o), 16'h0000);
    $display("test idle done");
  endtask

  initial begin
    rst_n_i = 1'b0;
    instr_valid_i = 1'b0;
    instr_i = 16'h0000;
    ext_set_en_i = 1'b0;
    index_base_i = 14'h1200;
    repeat (10) step();
    chk("phase reset", 16'(phase_o), 16'h0000);
    chk("busy reset", 16'(busy_o), 16'h0000);
    rst_n_i = 1'b1;
    t_bank();
    t_mul(8'he2, 8'hc4);
    t_mul(8'hff, 8'hff);
    // zero product after a nonzero one: nothing else may react
    t_mul(8'h12, 8'h00);
    exec({OP_LOAD_WORKING, 8'h4f});
    t_store(1'b1, 8'h23, 1'b0, 14'h0523, MODE_BANKED);
    t_store(1'b0, 8'h20, 1'b0, 14'h0020, MODE_ACCESS);
    t_store(1'b0, 8'h80, 1'b0, 14'h0480, MODE_ACCESS);
    t_store(1'b0, 8'h5f, 1'b1, 14'h125f, MODE_INDEXED);
    t_store(1'b0, 8'h60, 1'b1, 14'h0460, MODE_ACCESS);
    t_store(1'b1, 8'h10, 1'b1, 14'h0510, MODE_BANKED);
    exec({OP_LOAD_WORKING, 8'h00});
    chk("working", 16'(working_o), 16'h0000);
    chk("product", {product_high_o, product_low_o}, 16'h0000);
    t_idle();
    test_done();
  end

  // reset plus about 17 instructions of 160 ns each and an idle cycle; generous margin
  initial begin
    #20000;
    error_cnt++;
    test_done();
  end
endmodule // tb
